// ==== logic/fill_error_syndrome_defines.vh ====
// Offsets, field positions and codes for the fill error capture block
`ifndef FILL_ERROR_SYNDROME_DEFINES_VH
`define FILL_ERROR_SYNDROME_DEFINES_VH

`define FILL_ERR_SYN_OFFSET 40'hFFFFF00068
`define ERR_ADDR_OFFSET 40'hFFFFF00148
`define IPR_ADDR_W 40
`define FILL_ADDR_W 40
`define SYN_W 16
`define SYN_LO_MSB 7
`define SYN_LO_LSB 0
`define SYN_HI_MSB 15
`define SYN_HI_LSB 8
`define SYN_NONE 8'h00
`define RD_DATA_RESET 64'h0000000000000000

`endif

// ==== logic/fill_error_syndrome_capture.v ====
// Fill ECC/parity error capture: syndrome and error address registers
// Behaviour
// RULE1: Address register read-only, holds flagged error address
// RULE2: Address valid only while an error flag set
// RULE3: Syndrome register is read-only, sixteen bits
// RULE4: First correctable loads unlocked; later ones ignored
// RULE5: Uncorrectable or parity error loads and locks
// RULE6: Status read unlocks syndrome and address
// RULE7: Reset does not unlock the captures
// RULE8: ECC: low byte lower, high byte upper
// RULE9: Zero quadword syndrome means no error
// RULE10: Parity mode flags each bad byte
// RULE11: Check bit i error gives one-hot syndrome
// RULE12: Data bits 0-15 syndrome codes fixed
// RULE13: Data bits 16-31 syndrome codes fixed
// RULE14: Data bits 32-47 syndrome codes fixed
// RULE15: Data bits 48-63 syndrome codes fixed
// RULE16: Second uncorrectable only sets second-hard flag
// RULE17: Correctable after uncorrectable is not logged
// RULE18: Both flags: read clears correctable only
// RULE19: Syndrome is received XOR regenerated check
// RULE20: Address loads and locks like syndrome
`include "fill_error_syndrome_defines.vh"

module fill_error_syndrome_capture (
    input wire sys_clk,
    input wire nrst,
    input wire powerUpClear,
    input wire fillValid,
    input wire eccMode,
    input wire [`FILL_ADDR_W-1:0] fillAddr,
    input wire [127:0] fillData,
    input wire [15:0] fillCheck,
    input wire statusRead,
    input wire iprRead,
    input wire [`IPR_ADDR_W-1:0] iprAddr,
    output reg [63:0] iprRdData,
    output reg iprRdValid,
    output reg corErrFlag,
    output reg uncErrFlag,
    output reg secondHardFlag,
    output reg addrValid
);

    // Syndrome of a single-bit error in data bit idx
    function [7:0] dataSyn;
        input [5:0] idx;
        begin
            case (idx)
                // RULE12: bits 0-15 codes
                6'h00: dataSyn = 8'hCE;
                6'h01: dataSyn = 8'hCB;
                6'h02: dataSyn = 8'hD3;
                6'h03: dataSyn = 8'hD5;
                6'h04: dataSyn = 8'hD6;
                6'h05: dataSyn = 8'hD9;
                6'h06: dataSyn = 8'hDA;
                6'h07: dataSyn = 8'hDC;
                6'h08: dataSyn = 8'h23;
                6'h09: dataSyn = 8'h25;
                6'h0A: dataSyn = 8'h26;
                6'h0B: dataSyn = 8'h29;
                6'h0C: dataSyn = 8'h2A;
                6'h0D: dataSyn = 8'h2C;
                6'h0E: dataSyn = 8'h31;
                6'h0F: dataSyn = 8'h34;
                // RULE13: bits 16-31 codes
                6'h10: dataSyn = 8'h0E;
                6'h11: dataSyn = 8'h0B;
                6'h12: dataSyn = 8'h13;
                6'h13: dataSyn = 8'h15;
                6'h14: dataSyn = 8'h16;
                6'h15: dataSyn = 8'h19;
                6'h16: dataSyn = 8'h1A;
                6'h17: dataSyn = 8'h1C;
                6'h18: dataSyn = 8'hE3;
                6'h19: dataSyn = 8'hE5;
                6'h1A: dataSyn = 8'hE6;
                6'h1B: dataSyn = 8'hE9;
                6'h1C: dataSyn = 8'hEA;
                6'h1D: dataSyn = 8'hEC;
                6'h1E: dataSyn = 8'hF1;
                6'h1F: dataSyn = 8'hF4;
                // RULE14: bits 32-47 codes
                6'h20: dataSyn = 8'h4F;
                6'h21: dataSyn = 8'h4A;
                6'h22: dataSyn = 8'h52;
                6'h23: dataSyn = 8'h54;
                6'h24: dataSyn = 8'h57;
                6'h25: dataSyn = 8'h58;
                6'h26: dataSyn = 8'h5B;
                6'h27: dataSyn = 8'h5D;
                6'h28: dataSyn = 8'hA2;
                6'h29: dataSyn = 8'hA4;
                6'h2A: dataSyn = 8'hA7;
                6'h2B: dataSyn = 8'hA8;
                6'h2C: dataSyn = 8'hAB;
                6'h2D: dataSyn = 8'hAD;
                6'h2E: dataSyn = 8'hB0;
                6'h2F: dataSyn = 8'hB5;
                // RULE15: bits 48-63 codes
                6'h30: dataSyn = 8'h8F;
                6'h31: dataSyn = 8'h8A;
                6'h32: dataSyn = 8'h92;
                6'h33: dataSyn = 8'h94;
                6'h34: dataSyn = 8'h97;
                6'h35: dataSyn = 8'h98;
                6'h36: dataSyn = 8'h9B;
                6'h37: dataSyn = 8'h9D;
                6'h38: dataSyn = 8'h62;
                6'h39: dataSyn = 8'h64;
                6'h3A: dataSyn = 8'h67;
                6'h3B: dataSyn = 8'h68;
                6'h3C: dataSyn = 8'h6B;
                6'h3D: dataSyn = 8'h6D;
                6'h3E: dataSyn = 8'h70;
                default: dataSyn = 8'h75;
            endcase
        end
    endfunction

    // Check bits regenerated from a quadword
    function [7:0] genCheck;
        input [63:0] qw;
        integer i;
        reg [7:0] acc;
        begin
            acc = 8'h00;
            for (i = 0; i < 64; i = i + 1)
            begin
                if (qw[i])
                    acc = acc ^ dataSyn(i[5:0]);
            end
            genCheck = acc;
        end
    endfunction

    // Odd weight is a single-bit error; even nonzero is double
    function isSingle;
        input [7:0] s;
        begin
            isSingle = ^s;
        end
    endfunction

    wire [7:0] synLo;
    wire [7:0] synHi;
    wire [15:0] parErrBytes;
    // RULE19: received XOR regenerated
    assign synLo = fillCheck[7:0] ^ genCheck(fillData[63:0]);
    assign synHi = fillCheck[15:8] ^ genCheck(fillData[127:64]);

    // RULE10: even parity per byte, one check bit per byte
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1)
        begin : gParity
            assign parErrBytes[b] = ^{fillData[8*b+7:8*b], fillCheck[b]};
        end
    endgenerate

    // RULE9: zero syndrome means clean quadword
    wire loBad = (synLo != `SYN_NONE);
    wire hiBad = (synHi != `SYN_NONE);
    // RULE11: one-hot check-bit syndromes have odd weight, so correctable
    wire eccUnc = (loBad && !isSingle(synLo)) || (hiBad && !isSingle(synHi));
    wire eccCor = (loBad || hiBad) && !eccUnc;
    // Parity errors count as hard errors
    wire fillUnc = fillValid && (eccMode ? eccUnc : (parErrBytes != 16'h0000));
    wire fillCor = fillValid && eccMode && eccCor;

    // Flags and captures are deliberately not on nrst so a lock survives reset
    reg corReg;
    reg uncReg;
    reg hardReg;
    reg [`SYN_W-1:0] synReg;
    reg [`FILL_ADDR_W-1:0] addrReg;
    reg corNext;
    reg uncNext;
    reg hardNext;
    reg loadNext;

    always @*
    begin
        corNext = corReg;
        uncNext = uncReg;
        hardNext = hardReg;
        loadNext = 1'b0;
        if (statusRead)
        begin
            // RULE18: both set, read clears only the correctable flag
            if (corReg && uncReg)
                corNext = 1'b0;
            else
            begin
                // RULE6: read clears and unlocks
                corNext = 1'b0;
                uncNext = 1'b0;
                hardNext = 1'b0;
            end
        end
        // New events win over a same-cycle read
        if (fillUnc)
        begin
            // RULE16: second hard error only sets its flag
            if (uncNext)
                hardNext = 1'b1;
            else
            begin
                // RULE5: load and lock
                uncNext = 1'b1;
                loadNext = 1'b1;
            end
        end
        // RULE17: correctable under a hard lock is dropped
        else if (fillCor && !uncNext)
        begin
            // RULE4: only the first correctable loads
            if (!corNext)
                loadNext = 1'b1;
            corNext = 1'b1;
        end
    end

    // RULE7: only power-up clears, never nrst
    always @(posedge sys_clk)
    begin
        if (powerUpClear)
        begin
            corReg <= 1'b0;
            uncReg <= 1'b0;
            hardReg <= 1'b0;
        end
        else
        begin
            corReg <= corNext;
            uncReg <= uncNext;
            hardReg <= hardNext;
        end
    end

    always @(posedge sys_clk)
    begin
        if (loadNext)
        begin
            // RULE8: lower quadword in low byte, upper in high byte
            if (eccMode)
            begin
                synReg[`SYN_LO_MSB:`SYN_LO_LSB] <= synLo;
                synReg[`SYN_HI_MSB:`SYN_HI_LSB] <= synHi;
            end
            else
                synReg <= parErrBytes;
            // RULE20: address captured with the syndrome
            addrReg <= fillAddr;
        end
    end

    // Read port and flag outputs
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            iprRdData <= `RD_DATA_RESET;
            iprRdValid <= 1'b0;
            corErrFlag <= 1'b0;
            uncErrFlag <= 1'b0;
            secondHardFlag <= 1'b0;
            addrValid <= 1'b0;
        end
        else
        begin
            iprRdValid <= iprRead;
            // Outputs must track the internal clear, or they lag it by an edge
            if (powerUpClear)
            begin
                corErrFlag <= 1'b0;
                uncErrFlag <= 1'b0;
                secondHardFlag <= 1'b0;
                addrValid <= 1'b0;
            end
            else
            begin
                corErrFlag <= corNext;
                uncErrFlag <= uncNext;
                secondHardFlag <= hardNext;
                // RULE2: address meaningful only with a flag up
                addrValid <= corNext | uncNext;
            end
            if (iprRead)
            begin
                // RULE3: 16-bit read-only syndrome
                if (iprAddr == `FILL_ERR_SYN_OFFSET)
                    iprRdData <= {48'h000000000000, synReg};
                // RULE1: read-only error address
                else if (iprAddr == `ERR_ADDR_OFFSET)
                    iprRdData <= {24'h000000, addrReg};
                else
                    iprRdData <= `RD_DATA_RESET;
            end
        end
    end

endmodule // fill_error_syndrome_capture

// ==== testbench/fill_source_model.sv ====
// Fill data path model: octawords with check bits or byte parity
module fill_source_model #(
    parameter logic [511:0] COLS = '0
) (
    input wire logic sys_clk,
    input wire logic send,
    input wire logic ecc,
    input wire logic [39:0] addr,
    input wire logic [127:0] data,
    input wire logic [143:0] flip,
    output logic fillValid = 0,
    output logic [39:0] fillAddr = '0,
    output logic [127:0] fillData = '0,
    output logic [15:0] fillCheck = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] par;
    function automatic logic [7:0] gen(input logic [63:0] d);
        gen = 8'h00;
        for (int i = 0; i < 64; i++)
            if (d[i])
                gen ^= COLS[8*i +: 8];
    endfunction
    always_comb
        for (int b = 0; b < 16; b++)
            par[b] = ^data[8*b +: 8];
    // Idle address and data lines toggle so stale values never look valid
    always @(posedge sys_clk)
    begin
        fillValid <= send;
        fillAddr <= send ? addr : ~fillAddr;
        fillData <= send ? data ^ flip[127:0] : ~fillData;
        fillCheck <= (ecc ? {gen(data[127:64]), gen(data[63:0])} : par) ^ flip[143:128];
    end
endmodule // fill_source_model

// ==== testbench/fill_error_syndrome_capture_chk.sv ====
// Port checker for the fill error capture block
module fill_error_syndrome_capture_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic fillValid,
    input wire logic statusRead,
    input wire logic iprRead,
    input wire logic [63:0] iprRdData,
    input wire logic iprRdValid,
    input wire logic corErrFlag,
    input wire logic uncErrFlag,
    input wire logic secondHardFlag,
    input wire logic addrValid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence sBothRead;
        corErrFlag && uncErrFlag && statusRead;
    endsequence
    // Outputs are forced low in reset, so skip two edges after it
    sequence sSettled;
        nrst && $past(nrst) && $past(nrst, 2);
    endsequence
    AST_ADDR_VALID: assert property (addrValid == (corErrFlag || uncErrFlag))
        else $error("address valid wrong");
    AST_RD_ANSWER: assert property (iprRead |=> iprRdValid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (!iprRead |=> !iprRdValid && $stable(iprRdData))
        else $error("read data moved");
    AST_LOCK_HOLD: assert property (uncErrFlag && !statusRead |=> uncErrFlag)
        else $error("lock lost");
    AST_SECOND_HARD: assert property (sSettled ##0 $rose(secondHardFlag) |-> $past(uncErrFlag))
        else $error("second hard without lock");
    AST_COR_AFTER_UNC: assert property (sSettled ##0 $rose(corErrFlag) && !$past(statusRead)
        |-> !$past(uncErrFlag)) else $error("correctable logged after lock");
    AST_BOTH_READ: assert property (sBothRead |=> uncErrFlag && !corErrFlag)
        else $error("double flag read wrong");
    AST_CLEAR: assert property (sSettled ##0 statusRead && !fillValid
        && !(corErrFlag && uncErrFlag) |=> !corErrFlag && !uncErrFlag && !secondHardFlag)
        else $error("status read did not clear");
endmodule // fill_error_syndrome_capture_chk
bind fill_error_syndrome_capture fill_error_syndrome_capture_chk fill_error_syndrome_capture_chk_inst (
    .sys_clk, .nrst, .fillValid, .statusRead, .iprRead, .iprRdData, .iprRdValid, .corErrFlag,
    .uncErrFlag, .secondHardFlag, .addrValid);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the fill error capture block
`include "fill_error_syndrome_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [511:0] C = {64'h75706D6B68676462, 64'h9D9B989794928A8F,
        64'hB5B0ADABA8A7A4A2, 64'h5D5B585754524A4F, 64'hF4F1ECEAE9E6E5E3,
        64'h1C1A19161513_0B0E, 64'h34312C2A29262523, 64'hDCDAD9D6D5D3CBCE};
    logic sys_clk = 0, nrst = 0, powerUpClear = 1, eccMode = 1, statusRead = 0;
    logic iprRead = 0, send = 0, fillValid, iprRdValid;
    logic corErrFlag, uncErrFlag, secondHardFlag, addrValid;
    logic [39:0] iprAddr = '0, fillAddr, addr = '0;
    logic [127:0] fillData;
    logic [143:0] flip = '0;
    logic [15:0] fillCheck;
    logic [63:0] iprRdData;
    int mismatches = 0, testsRun = 0;
    always #10 sys_clk = ~sys_clk;
    fill_source_model #(.COLS(C)) fill_source_model_inst (.sys_clk, .send, .ecc(eccMode), .addr,
        .data(128'h0123456789ABCDEFFEDCBA9876543210), .flip, .fillValid, .fillAddr, .fillData,
        .fillCheck);
    fill_error_syndrome_capture fill_error_syndrome_capture_inst (.sys_clk, .nrst, .powerUpClear,
        .fillValid, .eccMode, .fillAddr, .fillData, .fillCheck, .statusRead, .iprRead, .iprAddr,
        .iprRdData, .iprRdValid, .corErrFlag, .uncErrFlag, .secondHardFlag, .addrValid);
    task automatic ck(input logic [63:0] g, input logic [63:0] e);
        testsRun++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [39:0] a, input logic [63:0] e);
        @(posedge sys_clk);
        iprRead <= 1;
        iprAddr <= a;
        @(posedge sys_clk);
        iprRead <= 0;
        #1;
        ck(iprRdValid, 1);
        ck(iprRdData, e);
    endtask
    task automatic fill(input logic [39:0] a, input logic [143:0] f);
        @(posedge sys_clk);
        send <= 1;
        addr <= a;
        flip <= f;
        @(posedge sys_clk);
        send <= 0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic stat();
        @(posedge sys_clk);
        statusRead <= 1;
        @(posedge sys_clk);
        statusRead <= 0;
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1;
        @(posedge sys_clk);
        powerUpClear <= 0;
        // One bit in each quadword, then check bits in the lower one
        for (int i = 0; i < 72; i++)
        begin
            fill(40'h10 + i, i < 64 ? 144'h1 << i | 144'h1 << 127 - i : 144'h1 << 64 + i);
            ck(corErrFlag, 1);
            rd(`FILL_ERR_SYN_OFFSET, i < 64 ? {C[8*(63-i) +: 8], C[8*i +: 8]} : 16'h1 << i - 64);
            stat();
        end
        fill(40'hA1, 144'h3);
        ck(uncErrFlag, 1);
        fill(40'hA2, 144'h3);
        ck(secondHardFlag, 1);
        fill(40'hA3, 144'h1);
        ck(corErrFlag, 0);
        @(posedge sys_clk);
        nrst <= 0;
        @(posedge sys_clk);
        nrst <= 1;
        @(posedge sys_clk);
        #1;
        ck(uncErrFlag, 1);
        rd(`ERR_ADDR_OFFSET, 64'hA1);
        rd(`FILL_ERR_SYN_OFFSET, 64'h5);
        stat();
        ck({corErrFlag, uncErrFlag, secondHardFlag, addrValid}, 0);
        fill(40'hB1, 144'h2);
        fill(40'hB2, 144'h1);
        rd(`ERR_ADDR_OFFSET, 64'hB1);
        fill(40'hB3, 144'h3);
        rd(`ERR_ADDR_OFFSET, 64'hB3);
        stat();
        ck({corErrFlag, uncErrFlag}, 1);
        stat();
        ck(uncErrFlag, 0);
        @(posedge sys_clk);
        eccMode <= 0;
        fill(40'hC1, 144'h1 << 24 | 144'h1 << 100);
        rd(`FILL_ERR_SYN_OFFSET, 64'h1008);
        rd(40'h0, 0);
        conclude();
    end
endmodule // tb_top
